// *** src/video_encoder_pkg.sv ***
package video_encoder_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int PIX_W = 10;
  localparam int HCNT_W = 12;
  localparam int VCNT_W = 11;
  localparam int CG_W = 20;
  localparam int CRC_W = 6;
  localparam int DELAY_MAX = 4;
  // device register offsets
  localparam logic [6:0] OFF_MODE_2 = 7'h02;
  localparam logic [6:0] OFF_MODE_3 = 7'h03;
  localparam logic [6:0] OFF_MODE_4 = 7'h04;
  localparam logic [6:0] OFF_MODE_5 = 7'h05;
  localparam logic [6:0] OFF_COLOR_Y = 7'h06;
  localparam logic [6:0] OFF_COLOR_CR = 7'h07;
  localparam logic [6:0] OFF_COLOR_CB = 7'h08;
  localparam logic [6:0] OFF_MODE_6 = 7'h09;
  localparam logic [6:0] OFF_CG_HIGH = 7'h13;
  // mode_control_2 fields
  localparam int LUMA_DELAY_LSB = 0;
  localparam int CHROMA_DELAY_LSB = 3;
  localparam int DELAY_FIELD_W = 3;
  localparam int BIT_CG_ENABLE = 6;
  localparam int BIT_CG_CRC = 7;
  // mode_control_3 fields
  localparam int BIT_HD_SELECT = 0;
  localparam int BIT_CONV_A = 3;
  localparam int BIT_CONV_B = 4;
  localparam int BIT_CONV_C = 5;
  localparam int BIT_INTERP = 6;
  localparam logic [7:0] MODE_3_RESERVED_MASK = 8'h86;
  // mode_control_4 fields
  localparam int BIT_TIMING_RESET = 0;
  // mode_control_5 fields
  localparam int BIT_REVISION = 0;
  localparam int BIT_RGB = 1;
  localparam int BIT_CHROMA_SYNC = 2;
  localparam int BIT_SWAP = 3;
  localparam int BIT_GAMMA_CURVE = 4;
  localparam int BIT_GAMMA_EN = 5;
  localparam int BIT_ADAPT_MODE = 6;
  localparam int BIT_ADAPT_EN = 7;
  // revision code, value arbitrary
  localparam logic REVISION_VALUE = 1'b0;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] MODE_6_PREP_VALUE = 8'h3e;
  localparam logic [1:0] STD_770_2 = 2'b00;
  localparam logic [1:0] STD_FULL_RANGE = 2'b10;
  localparam logic [VCNT_W-1:0] COPY_GEN_LINE = 11'h029;
  localparam logic [VCNT_W-1:0] FIRST_LINE = 11'h001;
  localparam logic [5:0] CRC_INIT = 6'h3f;
  localparam logic [5:0] CRC_POLY = 6'h03;
  // controller register offsets (apb byte addresses)
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam int CMD_WDATA_LSB = 0;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_WRITE_BIT = 16;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_RDATA_LSB = 8;
endpackage

// *** src/encoder_reg_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface encoder_reg_if;
  import video_encoder_pkg::*;
  logic req;
  logic write;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic ack;
  logic [DATA_W-1:0] rdata;
  modport host_end (output req, output write, output addr, output wdata,
                    input ack, input rdata);
  modport device_end (input req, input write, input addr, input wdata,
                      output ack, output rdata);
endinterface
`default_nettype wire

// *** src/encoder_host_end.sv ***
`timescale 1ns/1ns
`default_nettype none
module encoder_host_end (
  input wire logic clk,
  input wire logic rstn,
  encoder_reg_if.host_end link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import video_encoder_pkg::*;

  logic busy;
  logic [DATA_W-1:0] last_rdata;
  logic cmd_take;
  logic [ADDR_W-1:0] cmd_addr;
  logic [DATA_W-1:0] cmd_data;

  assign cmd_take = psel && penable && pready && pwrite && (paddr == OFF_CMD) && !busy;
  assign cmd_addr = pwdata[CMD_ADDR_LSB +: ADDR_W];
  assign cmd_data = (cmd_addr == OFF_MODE_3) ?
                    (pwdata[CMD_WDATA_LSB +: DATA_W] & ~MODE_3_RESERVED_MASK) :
                    pwdata[CMD_WDATA_LSB +: DATA_W];

  // apb answer one cycle after setup
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable && !pready;
      if (psel && !penable) begin
        prdata <= 32'h0000_0000;
        if (paddr == OFF_STATUS) begin
          prdata[STAT_BUSY_BIT] <= busy;
          prdata[STAT_RDATA_LSB +: DATA_W] <= last_rdata;
        end
      end
    end
  end

  // link request held until the device acknowledges
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'b0;
      link.req <= 1'b0;
      link.write <= 1'b0;
      link.addr <= '0;
      link.wdata <= '0;
      last_rdata <= '0;
    end else if (cmd_take) begin
      busy <= 1'b1;
      link.req <= 1'b1;
      link.write <= pwdata[CMD_WRITE_BIT];
      link.addr <= cmd_addr;
      link.wdata <= cmd_data;
    end else if (link.req && link.ack) begin
      busy <= 1'b0;
      link.req <= 1'b0;
      if (!link.write) begin
        last_rdata <= link.rdata;
      end
    end
  end
endmodule
`default_nettype wire

// *** src/encoder_device_end.sv ***
// Local design decision: register access over APB.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - luma delayed zero to four pixel clocks
// - both chroma paths delayed up to four
// - copy-gen word flagged on line 41, progressive
// - crc enable replaces check bits automatically
// - hd select one means hdtv mode
// - each converter powered down when bit cleared
// - interpolation bit engages double rate filters
// - host writes 3e to 09 before toggling
// - timing reset pulse clears timing counters
// - rgb mode treats pixels as unsigned rgb
// - chroma sync only when allowed standard, not rgb
// - 4:4:4 routes red to b, swap exchanges
// - 4:2:2 drives c from multiplexed port
// - curve select picks first or second curve
// - gamma bypassed unless gamma enable set
// - adaptive mode ignored unless both filters on
// - adaptive filtering needs adaptive and sharpness
// - three 8-bit test colour registers
// - upper copy-gen register holds bits 16-19
// - host writes zeros to reserved bits
// - host programs 235/128/16, then black 16/128
// - sharpness enable switches luma sharpness filter
module encoder_device_end (
  input wire logic clk,
  input wire logic rstn,
  encoder_reg_if.device_end link,
  input wire logic hsync_n,
  input wire logic vsync_n,
  input wire logic [video_encoder_pkg::PIX_W-1:0] pix_y,
  input wire logic [video_encoder_pkg::PIX_W-1:0] pix_cr,
  input wire logic [video_encoder_pkg::PIX_W-1:0] pix_cb,
  input wire logic input_422,
  input wire logic [1:0] output_standard_code,
  input wire logic sharpness_enable,
  input wire logic [15:0] copy_gen_low,
  output logic [video_encoder_pkg::PIX_W-1:0] dac_a_data,
  output logic [video_encoder_pkg::PIX_W-1:0] dac_b_data,
  output logic [video_encoder_pkg::PIX_W-1:0] dac_c_data,
  output logic dac_c_is_red,
  output logic conv_a_on,
  output logic conv_b_on,
  output logic conv_c_on,
  output logic interp_on,
  output logic hd_mode,
  output logic rgb_mode,
  output logic chroma_sync_on,
  output logic gamma_on,
  output logic gamma_curve,
  output logic sharpness_on,
  output logic adaptive_on,
  output logic adaptive_mode,
  output logic [7:0] test_luma,
  output logic [7:0] test_red_diff,
  output logic [7:0] test_blue_diff,
  output logic copy_gen_insert,
  output logic [video_encoder_pkg::CG_W-1:0] copy_gen_word,
  output logic [video_encoder_pkg::HCNT_W-1:0] h_count,
  output logic [video_encoder_pkg::VCNT_W-1:0] v_count
);
  import video_encoder_pkg::*;
  logic [7:0] mode_control_2;
  logic [7:0] mode_control_3;
  logic [7:0] mode_control_4;
  logic [7:0] mode_control_5;
  logic [7:0] mode_control_6;
  logic [7:0] test_color_luma;
  logic [7:0] test_color_red_diff;
  logic [7:0] test_color_blue_diff;
  logic [7:0] copy_gen_data_high;
  logic timing_reset_prev;
  logic hsync_prev;
  logic vsync_prev;
  logic [PIX_W-1:0] dly_y [DELAY_MAX+1];
  logic [PIX_W-1:0] dly_cr [DELAY_MAX+1];
  logic [PIX_W-1:0] dly_cb [DELAY_MAX+1];
  function automatic logic [2:0] clamp_delay(input logic [2:0] d);
    clamp_delay = (d > 3'(DELAY_MAX)) ? 3'(DELAY_MAX) : d;
  endfunction
  // crc x^6+x+1 over the first 14 bits, lsb first
  function automatic logic [CRC_W-1:0] cg_crc(input logic [13:0] bits);
    logic [CRC_W-1:0] c;
    logic fb;
    c = CRC_INIT;
    for (int i = 0; i < 14; i++) begin
      fb = bits[i] ^ c[CRC_W-1];
      c = {c[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : 6'h00);
    end
    cg_crc = c;
  endfunction
  wire logic take = link.req && !link.ack;
  // timing reset fires when the bit returns low
  wire logic timing_reset_pulse = timing_reset_prev && !mode_control_4[BIT_TIMING_RESET];
  wire logic hsync_fall = hsync_prev && !hsync_n;
  wire logic vsync_fall = vsync_prev && !vsync_n;
  wire logic [2:0] luma_delay = clamp_delay(mode_control_2[LUMA_DELAY_LSB +: DELAY_FIELD_W]);
  wire logic [2:0] chroma_delay = clamp_delay(mode_control_2[CHROMA_DELAY_LSB +: DELAY_FIELD_W]);
  wire logic [CG_W-1:0] raw_word = {copy_gen_data_high[3:0], copy_gen_low};
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_control_2 <= REG_RESET;
      mode_control_3 <= REG_RESET;
      mode_control_4 <= REG_RESET;
      mode_control_5 <= REG_RESET;
      mode_control_6 <= REG_RESET;
      test_color_luma <= REG_RESET;
      test_color_red_diff <= REG_RESET;
      test_color_blue_diff <= REG_RESET;
      copy_gen_data_high <= REG_RESET;
    end else if (take && link.write) begin
      case (link.addr)
        OFF_MODE_2: mode_control_2 <= link.wdata;
        OFF_MODE_3: mode_control_3 <= link.wdata;
        OFF_MODE_4: mode_control_4 <= link.wdata;
        OFF_MODE_5: mode_control_5 <= link.wdata;
        OFF_COLOR_Y: test_color_luma <= link.wdata;
        OFF_COLOR_CR: test_color_red_diff <= link.wdata;
        OFF_COLOR_CB: test_color_blue_diff <= link.wdata;
        OFF_MODE_6: mode_control_6 <= link.wdata;
        OFF_CG_HIGH: copy_gen_data_high <= link.wdata;
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      link.ack <= 1'b0;
      link.rdata <= '0;
    end else begin
      link.ack <= take;
      if (take) begin
        case (link.addr)
          OFF_MODE_2: link.rdata <= mode_control_2;
          OFF_MODE_3: link.rdata <= mode_control_3;
          OFF_MODE_4: link.rdata <= mode_control_4;
          OFF_MODE_5: link.rdata <= {mode_control_5[7:1], REVISION_VALUE};
          OFF_COLOR_Y: link.rdata <= test_color_luma;
          OFF_COLOR_CR: link.rdata <= test_color_red_diff;
          OFF_COLOR_CB: link.rdata <= test_color_blue_diff;
          OFF_MODE_6: link.rdata <= mode_control_6;
          OFF_CG_HIGH: link.rdata <= copy_gen_data_high;
          default: link.rdata <= '0;
        endcase
      end
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      timing_reset_prev <= 1'b0;
      hsync_prev <= 1'b1;
      vsync_prev <= 1'b1;
    end else begin
      timing_reset_prev <= mode_control_4[BIT_TIMING_RESET];
      hsync_prev <= hsync_n;
      vsync_prev <= vsync_n;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      h_count <= '0;
      v_count <= '0;
    end else if (timing_reset_pulse) begin
      h_count <= '0;
      v_count <= '0;
    end else begin
      h_count <= hsync_fall ? '0 : h_count + 1'b1;
      if (vsync_fall) begin
        v_count <= FIRST_LINE;
      end else if (hsync_fall) begin
        v_count <= v_count + 1'b1;
      end
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dly_y[0] <= '0;
      dly_cr[0] <= '0;
      dly_cb[0] <= '0;
    end else begin
      dly_y[0] <= pix_y;
      dly_cr[0] <= pix_cr;
      dly_cb[0] <= pix_cb;
    end
  end
  for (genvar i = 1; i <= DELAY_MAX; i++) begin : g_delay
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        dly_y[i] <= '0;
        dly_cr[i] <= '0;
        dly_cb[i] <= '0;
      end else begin
        dly_y[i] <= dly_y[i-1];
        dly_cr[i] <= dly_cr[i-1];
        dly_cb[i] <= dly_cb[i-1];
      end
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dac_a_data <= '0;
      dac_b_data <= '0;
      dac_c_data <= '0;
      dac_c_is_red <= 1'b0;
    end else begin
      dac_a_data <= dly_y[luma_delay];
      if (input_422) begin
        dac_b_data <= '0;
        dac_c_data <= dly_cb[chroma_delay];
        dac_c_is_red <= mode_control_5[BIT_SWAP];
      end else if (mode_control_5[BIT_SWAP]) begin
        dac_b_data <= dly_cb[chroma_delay];
        dac_c_data <= dly_cr[chroma_delay];
        dac_c_is_red <= 1'b1;
      end else begin
        dac_b_data <= dly_cr[chroma_delay];
        dac_c_data <= dly_cb[chroma_delay];
        dac_c_is_red <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      conv_a_on <= 1'b0;
      conv_b_on <= 1'b0;
      conv_c_on <= 1'b0;
      interp_on <= 1'b0;
      hd_mode <= 1'b0;
      rgb_mode <= 1'b0;
      chroma_sync_on <= 1'b0;
      gamma_on <= 1'b0;
      gamma_curve <= 1'b0;
      sharpness_on <= 1'b0;
      adaptive_on <= 1'b0;
      adaptive_mode <= 1'b0;
      test_luma <= '0;
      test_red_diff <= '0;
      test_blue_diff <= '0;
    end else begin
      conv_a_on <= mode_control_3[BIT_CONV_A];
      conv_b_on <= mode_control_3[BIT_CONV_B];
      conv_c_on <= mode_control_3[BIT_CONV_C];
      interp_on <= mode_control_3[BIT_INTERP];
      hd_mode <= mode_control_3[BIT_HD_SELECT];
      rgb_mode <= mode_control_5[BIT_RGB];
      chroma_sync_on <= mode_control_5[BIT_CHROMA_SYNC] && !mode_control_5[BIT_RGB] &&
                        (output_standard_code == STD_770_2 ||
                         output_standard_code == STD_FULL_RANGE);
      gamma_on <= mode_control_5[BIT_GAMMA_EN];
      gamma_curve <= mode_control_5[BIT_GAMMA_CURVE];
      sharpness_on <= sharpness_enable;
      adaptive_on <= mode_control_5[BIT_ADAPT_EN] && sharpness_enable;
      adaptive_mode <= mode_control_5[BIT_ADAPT_MODE] && mode_control_5[BIT_ADAPT_EN] &&
                       sharpness_enable;
      test_luma <= test_color_luma;
      test_red_diff <= test_color_red_diff;
      test_blue_diff <= test_color_blue_diff;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      copy_gen_insert <= 1'b0;
      copy_gen_word <= '0;
    end else begin
      copy_gen_insert <= mode_control_2[BIT_CG_ENABLE] && !mode_control_3[BIT_HD_SELECT] &&
                         (v_count == COPY_GEN_LINE);
      copy_gen_word <= mode_control_2[BIT_CG_CRC] ?
                       {cg_crc(raw_word[13:0]), raw_word[13:0]} : raw_word;
    end
  end
endmodule
`default_nettype wire

// *** tb/video_encoder_mode_control_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none
module video_encoder_mode_control_monitor (
  input wire logic clk,
  input wire logic rstn,
  input wire logic req,
  input wire logic write,
  input wire logic [video_encoder_pkg::ADDR_W-1:0] addr,
  input wire logic [video_encoder_pkg::DATA_W-1:0] wdata,
  input wire logic ack,
  input wire logic [video_encoder_pkg::DATA_W-1:0] rdata
);
  import video_encoder_pkg::*;
  logic [7:0] luma_shadow;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // last value written to the test luma register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      luma_shadow <= REG_RESET;
    end else if (ack && write && addr == OFF_COLOR_Y) begin
      luma_shadow <= wdata;
    end
  end
  chk_ack_single_pulse: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  chk_ack_latency: assert property (req && !ack |=> ack)
    else $error("ack not one cycle after request");
  chk_req_held: assert property (req && !ack |=> req && $stable({write, addr, wdata}))
    else $error("request changed before ack");
  chk_ack_with_req: assert property (ack |-> req)
    else $error("ack without request");
  chk_req_release: assert property (ack |=> !req)
    else $error("request not released after ack");
  chk_luma_readback: assert property (ack && !write && addr == OFF_COLOR_Y |-> rdata == luma_shadow)
    else $error("readback differs from last write");
  chk_reserved_zero: assert property (req && write && addr == OFF_MODE_3 |->
    (wdata & MODE_3_RESERVED_MASK) == 8'h00)
    else $error("reserved bits written as one");
  chk_unmapped_zero: assert property (ack && !write && addr == 7'h0a |-> rdata == 8'h00)
    else $error("unmapped offset read not zero");
  chk_revision_read: assert property (ack && !write && addr == OFF_MODE_5 |->
    rdata[BIT_REVISION] == REVISION_VALUE)
    else $error("revision bit wrong");
endmodule
`default_nettype wire

// *** tb/video_encoder_mode_control_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module video_encoder_mode_control_tb;
  import video_encoder_pkg::*;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic hsync_n, vsync_n, input_422, sharpness_enable;
  logic [PIX_W-1:0] pix_y, pix_cr, pix_cb, dac_a_data, dac_b_data, dac_c_data;
  logic [1:0] output_standard_code;
  logic [15:0] copy_gen_low;
  logic dac_c_is_red, conv_a_on, conv_b_on, conv_c_on, interp_on, hd_mode, rgb_mode;
  logic chroma_sync_on, gamma_on, gamma_curve, sharpness_on, adaptive_on, adaptive_mode;
  logic copy_gen_insert;
  logic [7:0] test_luma, test_red_diff, test_blue_diff;
  logic [CG_W-1:0] copy_gen_word;
  logic [VCNT_W-1:0] v_count;
  logic [HCNT_W-1:0] h_count;
  int fails = 0;
  int checked = 0;
  encoder_reg_if link_bus ();
  encoder_host_end encoder_host_end_inst (.clk, .rstn, .link(link_bus), .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  encoder_device_end encoder_device_end_inst (.clk, .rstn, .link(link_bus), .hsync_n,
    .vsync_n, .pix_y, .pix_cr, .pix_cb, .input_422, .output_standard_code,
    .sharpness_enable, .copy_gen_low, .dac_a_data, .dac_b_data, .dac_c_data, .dac_c_is_red,
    .conv_a_on, .conv_b_on, .conv_c_on, .interp_on, .hd_mode, .rgb_mode, .chroma_sync_on,
    .gamma_on, .gamma_curve, .sharpness_on, .adaptive_on, .adaptive_mode, .test_luma,
    .test_red_diff, .test_blue_diff, .copy_gen_insert, .copy_gen_word, .h_count,
    .v_count);
  video_encoder_mode_control_monitor mon_inst (.clk, .rstn, .req(link_bus.req),
    .write(link_bus.write), .addr(link_bus.addr), .wdata(link_bus.wdata),
    .ack(link_bus.ack), .rdata(link_bus.rdata));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ramp pixel source
  always @(posedge clk) begin
    pix_y <= pix_y + 10'h001;
    pix_cr <= pix_y + 10'h100;
  end
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic dev_access(input logic wr, input logic [6:0] off, input logic [7:0] d,
                            output logic [7:0] q);
    logic [31:0] r;
    apb(1'b1, OFF_CMD, {15'h0000, wr, 1'b0, off, d}, r);
    r = 32'h1;
    while (r[STAT_BUSY_BIT] !== 1'b0) begin
      apb(1'b0, OFF_STATUS, 32'h0, r);
    end
    q = r[STAT_RDATA_LSB +: 8];
  endtask
  task automatic wr(input logic [6:0] off, input logic [7:0] d);
    logic [7:0] q;
    dev_access(1'b1, off, d, q);
  endtask
  task automatic rd_cmp(input logic [6:0] off, input logic [7:0] exp);
    logic [7:0] q;
    dev_access(1'b0, off, 8'h00, q);
    cmp({24'h0, q}, {24'h0, exp});
  endtask
  task automatic test_colors;
    logic [7:0] v [3] = '{8'heb, 8'h80, 8'h10};
    logic [31:0] r;
    for (int i = 0; i < 3; i++) wr(OFF_COLOR_Y + 7'(i), v[i]);
    for (int i = 0; i < 3; i++) rd_cmp(OFF_COLOR_Y + 7'(i), v[i]);
    idle(2);
    cmp({8'h0, test_luma, test_red_diff, test_blue_diff}, {8'h0, v[0], v[1], v[2]});
    for (int i = 0; i < 3; i++) wr(OFF_COLOR_Y + 7'(i), (i == 0) ? 8'h10 : 8'h80);
    idle(2);
    cmp({8'h0, test_luma, test_red_diff, test_blue_diff}, 32'h0010_8080);
    rd_cmp(7'h0a, 8'h00);
    apb(1'b0, 8'h08, 32'h0, r);
    cmp(r, 32'h0);
    cmp(32'(pslverr), 32'h0);
  endtask
  task automatic test_mode3;
    logic [7:0] vals [4] = '{8'hff, 8'h51, 8'h00, 8'h28};
    wr(OFF_MODE_6, MODE_6_PREP_VALUE);
    rd_cmp(OFF_MODE_6, MODE_6_PREP_VALUE);
    foreach (vals[i]) begin
      wr(OFF_MODE_3, vals[i]);
      idle(2);
      cmp(32'({hd_mode, conv_a_on, conv_b_on, conv_c_on, interp_on}),
          32'({vals[i][0], vals[i][3], vals[i][4], vals[i][5], vals[i][6]}));
      rd_cmp(OFF_MODE_3, vals[i] & ~MODE_3_RESERVED_MASK);
    end
  endtask
  task automatic test_mode5;
    logic [7:0] vals [4] = '{8'hfc, 8'hc4, 8'h04, 8'h3e};
    logic s, sync;
    foreach (vals[i]) begin
      s = i[0];
      sync = vals[i][2] & !vals[i][1] & (i == 0 || i == 2);
      output_standard_code <= 2'(i);
      sharpness_enable <= s;
      wr(OFF_MODE_5, vals[i]);
      idle(2);
      cmp(32'({rgb_mode, chroma_sync_on, gamma_curve, gamma_on, sharpness_on, adaptive_on,
               adaptive_mode}), 32'({vals[i][1], sync, vals[i][4], vals[i][5], s,
               vals[i][7] & s, vals[i][6] & vals[i][7] & s}));
      rd_cmp(OFF_MODE_5, {vals[i][7:1], REVISION_VALUE});
    end
  endtask
  task automatic test_routing;
    pix_cb <= 10'h2a5;
    for (int m = 0; m < 2; m++) begin
      for (int s = 0; s < 2; s++) begin
        input_422 <= m[0];
        wr(OFF_MODE_5, 8'(s) << BIT_SWAP);
        idle(4);
        if (m == 1) begin
          cmp(32'({dac_b_data, dac_c_data, dac_c_is_red}), 32'({10'h000, 10'h2a5, s[0]}));
        end else begin
          cmp(32'(s == 1 ? dac_b_data : dac_c_data), 32'h2a5);
        end
      end
    end
    input_422 <= 1'b0;
    wr(OFF_MODE_5, 8'h00);
  endtask
  task automatic test_delay;
    int d [4] = '{0, 1, 4, 7};
    int k;
    foreach (d[i]) begin
      wr(OFF_MODE_2, 8'((d[i] << 3) | d[i]));
      idle(6);
      k = d[i] > DELAY_MAX ? DELAY_MAX : d[i];
      cmp(32'(dac_a_data), 32'(pix_y - 10'(k + 2)));
      cmp(32'(dac_b_data), 32'(pix_cr - 10'(k + 2)));
    end
  endtask
  task automatic test_copy_gen;
    logic [5:0] c;
    logic fb;
    copy_gen_low <= 16'h1234;
    wr(OFF_CG_HIGH, 8'h0b);
    wr(OFF_MODE_2, 8'h40);
    idle(2);
    cmp(32'(copy_gen_word), 32'h000b1234);
    wr(OFF_MODE_2, 8'hc0);
    idle(2);
    c = CRC_INIT;
    for (int i = 0; i < 14; i++) begin
      fb = c[5] ^ copy_gen_low[i];
      c = {c[4:0], fb} ^ {4'h0, fb, 1'b0};
    end
    cmp(32'(copy_gen_word), 32'({c, 14'h1234}));
    vsync_n <= 1'b0;
    idle(1);
    vsync_n <= 1'b1;
    repeat (40) begin
      hsync_n <= 1'b0;
      idle(1);
      hsync_n <= 1'b1;
      idle(3);
    end
    idle(2);
    cmp(32'({v_count, copy_gen_insert}), 32'({COPY_GEN_LINE, 1'b1}));
    cmp(32'(h_count), 32'h4);
    wr(OFF_MODE_4, 8'h01);
    cmp(32'(v_count), 32'(COPY_GEN_LINE));
    wr(OFF_MODE_4, 8'h00);
    idle(2);
    cmp(32'(v_count), 32'h0);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    rstn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {hsync_n, vsync_n, input_422, sharpness_enable} = 4'hc;
    {pix_y, pix_cr, pix_cb, output_standard_code, copy_gen_low} = '0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    test_colors;
    test_mode3;
    test_mode5;
    test_routing;
    test_delay;
    test_copy_gen;
    wrap_up;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    wrap_up;
  end
endmodule
`default_nettype wire
